// ===== core/thermal_fan_defs.svh
`ifndef THERMAL_FAN_DEFS_SVH
`define THERMAL_FAN_DEFS_SVH

// =====================================================================
// Register map
`define CFG3_ADDR        8'h3F
`define CFG3_EN_BIT      7
`define CFG3_RSVD_HI     6
`define CFG3_RSVD_LO     4
`define CFG3_REV_HI      3
`define CFG3_REV_LO      0

// =====================================================================
// Reset and fixed values
`define CFG3_EN_RESET    1'b1
`define CFG3_RSVD_VALUE  3'h0
`define UNMAPPED_RDATA   8'h00
`define RDATA_RESET      8'h00
// Arbitrary neutral revision code
`define REV_DEFAULT      4'h5

// =====================================================================
// Fan drive
`define FULL_DUTY        8'hFF
`define DUTY_RESET       8'h00

`endif

// ===== core/fan_cfg_pkg.sv
package fan_cfg_pkg;

  // =====================================================================
  // Register bank state
  typedef struct packed
  {
    logic       alert_fan_en;
    logic [7:0] rdata;
  } cfg_state_t;

  // =====================================================================
  // Fan drive state
  typedef struct packed
  {
    logic [7:0] duty;
    logic       full;
  } fan_state_t;

  // =====================================================================
  // Source of the fan demand
  typedef enum logic [2:0]
  {
    SRC_NORMAL = 3'b001,
    SRC_SELF   = 3'b010,
    SRC_EXT    = 3'b100
  } fan_src_t;

endpackage

// ===== core/fan_ctrl_if.sv
`timescale 1ns/1ns

interface fan_ctrl_if;
  logic       ce;
  logic       alert_fan_en;
  logic       self_drive;
  logic       ext_low;
  logic [7:0] duty_req;
  logic [7:0] duty_out;
  logic       full_speed;

  modport bank
  (
    output ce,
    output alert_fan_en,
    output self_drive,
    output ext_low,
    output duty_req,
    input  duty_out,
    input  full_speed
  );

  modport drive
  (
    input  ce,
    input  alert_fan_en,
    input  self_drive,
    input  ext_low,
    input  duty_req,
    output duty_out,
    output full_speed
  );
endinterface

// ===== core/fan_override.sv
`timescale 1ns/1ns
`include "thermal_fan_defs.svh"

module fan_override
  import fan_cfg_pkg::*;
(
  // Clock and reset
  input wire logic  clock,
  input wire logic  reset,
  // Control from the register bank
  fan_ctrl_if.drive fan
);

  fan_state_t s_q;
  fan_state_t s_d;
  fan_src_t   src;

  // =====================================================================
  // Demand selection
  always_comb
  begin
    s_d = s_q;
    src = SRC_NORMAL;
    if (fan.ext_low)
    begin
      src = SRC_EXT;
    end
    else if (fan.self_drive && fan.alert_fan_en)
    begin
      src = SRC_SELF;
    end
    case (src)
      SRC_NORMAL:
      begin
        s_d.duty = fan.duty_req;
        s_d.full = 1'b0;
      end
      SRC_SELF:
      begin
        s_d.duty = `FULL_DUTY;
        s_d.full = 1'b1;
      end
      SRC_EXT:
      begin
        s_d.duty = `FULL_DUTY;
        s_d.full = 1'b1;
      end
      default:
      begin
        s_d.duty = fan.duty_req;
        s_d.full = 1'b0;
      end
    endcase
    if (!fan.ce)
    begin
      s_d = s_q;
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_q.duty <= `DUTY_RESET;
      s_q.full <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign fan.duty_out   = s_q.duty;
  assign fan.full_speed = s_q.full;

endmodule

// ===== core/thermal_override_fan_config.sv
`timescale 1ns/1ns
`include "thermal_fan_defs.svh"

// Behaviour
// - Enable set and self-driven alert forces full
// - Enable clear: self alert keeps normal duty
// - Enable ignored while line pulled externally
// - External pull forces full fan speed only while our own driver is off
// - Enable bit resets to one
// - Bits 3..0 read-only revision, MSB bit 3
module thermal_override_fan_config
  import fan_cfg_pkg::*;
#(
  parameter logic [3:0] REVISION = `REV_DEFAULT
)
(
  // Clock, reset, enable
  input  wire logic       CLOCK,
  input  wire logic       RESET,
  input  wire logic       CLK_EN,
  // Register access at the device register address
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  output wire logic [7:0] REG_RDATA,
  // Over-temperature line, open drain
  input  wire logic       OVER_TEMP_ASSERT,
  input  wire logic       OVER_TEMP_LINE_I,
  output wire logic       OVER_TEMP_LINE_O,
  output wire logic       OVER_TEMP_LINE_OE,
  // Fan drive
  input  wire logic [7:0] DUTY_REQ,
  output wire logic [7:0] FAN_DUTY,
  output wire logic       FAN_FULL_SPEED
);

  localparam logic [2:0] RSVD_VALUE = `CFG3_RSVD_VALUE;

  cfg_state_t c_q;
  cfg_state_t c_d;
  logic       addr_hit;
  logic       wr_take;
  logic       rd_take;
  logic [7:0] cfg_word;
  logic [7:0] wr_mask;
  logic [7:0] fixed_bits;
  logic [7:0] live_bits;
  logic [7:0] next_word;
  logic       line_low;
  logic       self_pull;
  logic       ext_pull;

  fan_ctrl_if fan ();

  // =====================================================================
  // Access decode
  assign addr_hit = (REG_ADDR == `CFG3_ADDR);
  // Nothing is taken while the enable is low
  assign wr_take  = CLK_EN && REG_WR && addr_hit;
  assign rd_take  = CLK_EN && REG_RD;

  // =====================================================================
  // Per-bit field map
  genvar k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_bit
      if (k == `CFG3_EN_BIT)
      begin : g_en
        assign wr_mask[k]    = 1'b1;
        assign fixed_bits[k] = 1'b0;
        assign live_bits[k]  = c_q.alert_fan_en;
      end
      else if (k >= `CFG3_RSVD_LO && k <= `CFG3_RSVD_HI)
      begin : g_rsvd
        assign wr_mask[k]    = 1'b0;
        assign fixed_bits[k] = RSVD_VALUE[k - `CFG3_RSVD_LO];
        assign live_bits[k]  = 1'b0;
      end
      else
      begin : g_rev
        assign wr_mask[k]    = 1'b0;
        assign fixed_bits[k] = REVISION[k - `CFG3_REV_LO];
        assign live_bits[k]  = 1'b0;
      end
    end
  endgenerate

  // =====================================================================
  // Register image
  assign cfg_word  = live_bits | fixed_bits;
  // Masked bits keep their image, so read-only fields ignore writes
  assign next_word = (REG_WDATA & wr_mask) | (cfg_word & ~wr_mask);

  // =====================================================================
  // Register access
  always_comb
  begin
    c_d = c_q;
    if (wr_take)
    begin
      c_d.alert_fan_en = next_word[`CFG3_EN_BIT];
    end
    if (rd_take)
    begin
      // Read sees the value from before a same-cycle write
      c_d.rdata = addr_hit ? cfg_word : `UNMAPPED_RDATA;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      c_q.alert_fan_en <= `CFG3_EN_RESET;
      c_q.rdata        <= `RDATA_RESET;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // =====================================================================
  // Over-temperature line
  assign OVER_TEMP_LINE_O  = 1'b0;
  assign OVER_TEMP_LINE_OE = OVER_TEMP_ASSERT;

  assign line_low  = !OVER_TEMP_LINE_I;
  assign self_pull = OVER_TEMP_ASSERT;
  // Low with our driver off means another party pulls it
  assign ext_pull  = line_low && !self_pull;

  // =====================================================================
  // Fan override
  assign fan.ce           = CLK_EN;
  assign fan.alert_fan_en = c_q.alert_fan_en;
  assign fan.self_drive   = self_pull;
  assign fan.ext_low      = ext_pull;
  assign fan.duty_req     = DUTY_REQ;

  fan_override u_override
  (
    .clock (CLOCK),
    .reset (RESET),
    .fan   (fan.drive)
  );

  assign REG_RDATA      = c_q.rdata;
  assign FAN_DUTY       = fan.duty_out;
  assign FAN_FULL_SPEED = fan.full_speed;

endmodule

// ===== dv/fan_cfg_sva.sv
`timescale 1ns/1ns
module fan_cfg_sva
  import fan_cfg_pkg::*;
#(parameter logic [3:0] REVISION = 4'h5)
(
  input wire logic CLOCK, RESET, CLK_EN, REG_WR, REG_RD, OVER_TEMP_ASSERT,
  input wire logic OVER_TEMP_LINE_I, OVER_TEMP_LINE_OE, FAN_FULL_SPEED, OVER_TEMP_LINE_O,
  input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, DUTY_REQ, FAN_DUTY
);
  logic en_q;
  wire rd = CLK_EN && REG_RD;
  wire hit = REG_ADDR == 8'h3F;
  wire ext = !OVER_TEMP_LINE_I && !OVER_TEMP_ASSERT;
  // Shadow of the enable bit
  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
      en_q <= 1'b1;
    else if (CLK_EN && REG_WR && hit)
      en_q <= REG_WDATA[7];
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_ext_full: assert property (CLK_EN && ext |=> FAN_DUTY == 8'hFF)
    else $error("not full");
  a_self_full: assert property (CLK_EN && OVER_TEMP_ASSERT && en_q |=> FAN_FULL_SPEED)
    else $error("not forced");
  a_self_quiet: assert property
    (CLK_EN && OVER_TEMP_ASSERT && !en_q |=> FAN_DUTY == $past(DUTY_REQ))
    else $error("not quiet");
  a_en_read: assert property (rd && hit |=> REG_RDATA[7] == $past(en_q))
    else $error("bad enable");
  a_rev_read: assert property (rd && hit |=> REG_RDATA[3:0] == REVISION)
    else $error("bad revision");
  a_rsvd_zero: assert property (rd |=> REG_RDATA[6:4] == 3'h0)
    else $error("bad reserved");
  a_oe_drive: assert property (OVER_TEMP_LINE_OE == OVER_TEMP_ASSERT)
    else $error("bad drive");
  a_rd_hold: assert property (!rd |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_line_low: assert property (OVER_TEMP_LINE_O == 1'b0)
    else $error("line not open drain");
  a_freeze_hold: assert property (!CLK_EN |=> $stable(FAN_DUTY) && $stable(REG_RDATA))
    else $error("state moved while frozen");
  c_ext: cover property (ext);
  c_quiet: cover property (OVER_TEMP_ASSERT && !en_q);
  c_rw: cover property (rd && REG_WR && hit);
endmodule
bind thermal_override_fan_config fan_cfg_sva #(.REVISION(REVISION)) u_sva (.*);

// ===== dv/over_temp_line_model.sv
`timescale 1ns/1ns
module over_temp_line_model
(
  // Far side pull and device drive
  input  wire logic pull,
  input  wire logic oe,
  // Wire with pull-up
  output wire logic line
);
  assign line = !(pull || oe);
endmodule

// ===== dv/thermal_override_fan_config_test.sv
`timescale 1ns/1ns
module thermal_override_fan_config_test
  import fan_cfg_pkg::*;
;
  localparam logic [3:0] REV = 4'hA;
  logic CLOCK = 0, RESET = 1, CLK_EN = 1, REG_WR = 0, REG_RD = 0;
  logic OVER_TEMP_ASSERT = 0, pull = 0, en = 1, rp = 0, fp = 0, fv = 0;
  logic [7:0] REG_ADDR = 0, REG_WDATA = 0, DUTY_REQ = 0;
  wire logic [7:0] REG_RDATA, FAN_DUTY;
  wire logic OVER_TEMP_LINE_I, OVER_TEMP_LINE_O, OVER_TEMP_LINE_OE, FAN_FULL_SPEED;
  integer fails = 0, comparisons = 0, seed = 18482, cyc = 0, i;
  logic [7:0] rq[$];
  logic [8:0] fq[$];
  always #5 CLOCK = ~CLOCK;
  over_temp_line_model i_line (.pull(pull), .oe(OVER_TEMP_LINE_OE), .line(OVER_TEMP_LINE_I));
  thermal_override_fan_config #(.REVISION(REV)) i_dut (.*);
  task summarize;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cmp_rd(input [7:0] e, g);
    comparisons++;
    if (e !== g)
    begin
      fails++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task cmp_fan(input [8:0] e, g);
    comparisons++;
    if (e !== g)
    begin
      fails++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task acc(input w, r, input [7:0] a, d);
    fv = 0;
    REG_WR = w;
    REG_RD = r;
    REG_ADDR = a;
    REG_WDATA = d;
    if (r && CLK_EN)
      rq.push_back(a == 8'h3F ? {en, 3'h0, REV} : 8'h00);
    if (w && CLK_EN && a == 8'h3F)
      en = d[7];
    @(posedge CLOCK);
    #1;
  endtask
  task ot(input as, ext);
    REG_WR = 0;
    REG_RD = 0;
    fv = 1;
    OVER_TEMP_ASSERT = as;
    pull = ext;
    DUTY_REQ = 8'($random(seed));
    fq.push_back((as ? en : ext) ? 9'h1FF : {1'b0, DUTY_REQ});
    @(posedge CLOCK);
    #1;
  endtask
  // Results land one cycle after the request
  always @(negedge CLOCK)
  begin
    if (rp)
      cmp_rd(rq.pop_front(), REG_RDATA);
    if (fp)
      cmp_fan(fq.pop_front(), {FAN_FULL_SPEED, FAN_DUTY});
    rp = REG_RD && CLK_EN;
    fp = fv;
  end
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 500)
    begin
      fails++;
      summarize;
    end
  end
  initial
  begin
    repeat (3) @(posedge CLOCK);
    #1 RESET = 0;
    acc(0, 1, 8'h3F, 8'h00);
    for (i = 0; i < 4; i++)
      acc(1, 1, 8'h3F, 8'($random(seed)));
    acc(1, 1, 8'h04, 8'hFF);
    acc(0, 1, 8'h3F, 8'h00);
    $display("register test done");
    for (i = 0; i < 8; i++)
    begin
      acc(1, 0, 8'h3F, {i[2], 7'h7F});
      acc(0, 1, 8'h3F, 8'h00);
      ot(i[1], i[0]);
    end
    $display("fan test done");
    CLK_EN = 0;
    acc(1, 0, 8'h3F, 8'h00);
    CLK_EN = 1;
    acc(0, 1, 8'h3F, 8'h00);
    acc(0, 0, 8'h00, 8'h00);
    $display("freeze test done");
    summarize;
  end
endmodule
